/* File: src/sssl_map.vh */
// timing constants and state codes for the supply supervisor logic
`ifndef SSSL_MAP_VH
`define SSSL_MAP_VH

// ----------------------------------------------------------------
// clock and timebase
// ----------------------------------------------------------------
`define SSSL_CLK_PERIOD_NS   4
`define SSSL_TICK_NS         1000000
`define SSSL_TICK_CYC        (`SSSL_TICK_NS / `SSSL_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// periods in timebase ticks of one millisecond; the test pulse is also given in seconds and the test interval in hours
// ----------------------------------------------------------------
`define SSSL_RST_TIMEOUT_MS  200
`define SSSL_WDOG_PERIOD_MS  1000
`define SSSL_TEST_PULSE_S    1.3
`define SSSL_TEST_PULSE_MS   1300
`define SSSL_TEST_INTV_H     24
`define SSSL_TEST_INTV_MS    (`SSSL_TEST_INTV_H * 3600 * 1000)

// ----------------------------------------------------------------
// counter widths
// ----------------------------------------------------------------
`define SSSL_TICK_W          18
`define SSSL_HOLD_W          16
`define SSSL_WDOG_W          16
`define SSSL_INTV_W          27

// ----------------------------------------------------------------
// state codes
// ----------------------------------------------------------------
`define SSSL_ST_MAIN         1'b0
`define SSSL_ST_BACKUP       1'b1
`define SSSL_ST_IDLE         1'b0
`define SSSL_ST_TEST         1'b1

`endif

/* File: src/sssl_sync.v */
// two flip-flop synchroniser for a group of asynchronous inputs
module sssl_sync #(
  parameter WIDTH = 1
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] init_val,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      stage1   <= init_val;
      sync_out <= init_val;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* File: src/sssl_hold_timer.v */
// stretches a cause level by a number of timebase ticks after it clears
module sssl_hold_timer #(
  parameter CNT_W      = 16,
  parameter HOLD_TICKS = 200
) (
  input  wire mclk,
  input  wire rst,
  input  wire tick,
  input  wire cause,
  output reg  active
);

  localparam [CNT_W-1:0] LAST = HOLD_TICKS[CNT_W-1:0] - 1'b1;

  reg [CNT_W-1:0] cnt;

  // ----------------------------------------------------------------
  // hold counter
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      active <= 1'b1;
      cnt    <= {CNT_W{1'b0}};
    end else if (cause) begin
      active <= 1'b1;
      cnt    <= {CNT_W{1'b0}};
    end else if (active && tick) begin
      if (cnt == LAST) begin
        active <= 1'b0;
        cnt    <= {CNT_W{1'b0}};
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule

/* File: src/sssl_top.v */
// digital control of the supply supervisor: resets, watchdog, backup, battery test
//
// Functional notes
// - switch to backup only when supply is below threshold and battery above supply.
// - return to main supply once supply exceeds 1.01 times battery.
// - manual reset low asserts reset, held for the timeout after release.
// - high reset asserts on low supply or manual reset, held for timeout.
// - watchdog output goes low when kick input idles longer than its period.
// - any kick edge or asserted reset restarts the watchdog count.
// - watchdog output released on next kick transition or on reset.
// - undriven kick input disables the watchdog; timeouts are suppressed.
// - low-line warning low when supply falls within 2.5% above threshold.
// - battery test every 24 hours pulls open-drain test output low for 1.3s.
// - battery below 2.6V during a test drives battery-ok low.
// - battery-ok low when battery below ok threshold or on backup.
// - battery-on indicator high for the whole backup mode.
// - power-fail low below 0.6V, high only above threshold plus hysteresis.
// - undriven manual reset reads inactive through the pullup.
`include "sssl_map.vh"

module sssl_top #(
  parameter TICK_CYC        = `SSSL_TICK_CYC,
  parameter RST_TIMEOUT_MS  = `SSSL_RST_TIMEOUT_MS,
  parameter WDOG_PERIOD_MS  = `SSSL_WDOG_PERIOD_MS,
  parameter TEST_PULSE_MS   = `SSSL_TEST_PULSE_MS,
  parameter TEST_INTV_MS    = `SSSL_TEST_INTV_MS,
  parameter TICK_W          = `SSSL_TICK_W,
  parameter HOLD_W          = `SSSL_HOLD_W,
  parameter WDOG_W          = `SSSL_WDOG_W,
  parameter INTV_W          = `SSSL_INTV_W
) (
  input  wire mclk,
  input  wire rst,
  input  wire vcc_below_th,
  input  wire backup_cell_in_above_vcc,
  input  wire vcc_above_backup_cell_in_scaled,
  input  wire vcc_lowline,
  input  wire cell_below_ok,
  input  wire cell_below_test,
  input  wire pfi_below,
  input  wire pfi_above_hys,
  input  wire manual_rst_n,
  input  wire manual_rst_drive,
  input  wire wdog_kick,
  input  wire wdog_kick_drive,
  output reg  rst_n,
  output reg  rst_hi,
  output reg  wdog_expired_n,
  output reg  lowline_warn_n,
  output reg  cell_check_pulse_n,
  output reg  cell_check_pulse_oe,
  output reg  cell_good,
  output reg  on_backup,
  output reg  powerfail_n
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam [TICK_W-1:0] TICK_LAST  = TICK_CYC[TICK_W-1:0] - 1'b1;
  localparam [WDOG_W-1:0] WDOG_LAST  = WDOG_PERIOD_MS[WDOG_W-1:0] - 1'b1;
  localparam [INTV_W-1:0] INTV_LAST  = TEST_INTV_MS[INTV_W-1:0] - 1'b1;
  localparam [INTV_W-1:0] PULSE_LAST = TEST_PULSE_MS[INTV_W-1:0] - 1'b1;

  localparam ST_MAIN   = `SSSL_ST_MAIN;
  localparam ST_BACKUP = `SSSL_ST_BACKUP;
  localparam ST_IDLE   = `SSSL_ST_IDLE;
  localparam ST_TEST   = `SSSL_ST_TEST;

  localparam [11:0] SYNC_INIT = 12'h180;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function interval_done;
    input [INTV_W-1:0] cnt;
    input [INTV_W-1:0] last;
    begin
      interval_done = (cnt == last);
    end
  endfunction

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  wire [11:0]       pins_s;
  wire              vcc_below_s;
  wire              backup_cell_in_above_s;
  wire              vcc_above_s;
  wire              lowline_s;
  wire              cell_low_s;
  wire              cell_test_low_s;
  wire              pfi_below_s;
  wire              pfi_above_s;
  wire              mr_level_s;
  wire              mr_drive_s;
  wire              kick_s;
  wire              kick_drive_s;
  wire              mr_active;
  wire              rst_cause;
  wire              rst_hold;
  wire              kick_edge;
  wire              wdog_enabled;

  reg  [TICK_W-1:0] tick_cnt;
  reg               tick;
  reg               kick_prev;
  reg  [WDOG_W-1:0] wdog_cnt;
  reg               wdog_fired;
  reg               backup_state;
  reg               next_backup_state;
  reg               test_state;
  reg               next_test_state;
  reg  [INTV_W-1:0] intv_cnt;
  reg  [INTV_W-1:0] pulse_cnt;
  reg               test_low_seen;
  reg               cell_failed;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  sssl_sync #(
    .WIDTH (12)
  ) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({wdog_kick_drive, wdog_kick, manual_rst_drive, manual_rst_n,
                pfi_above_hys, pfi_below, cell_below_test, cell_below_ok,
                vcc_lowline, vcc_above_backup_cell_in_scaled, backup_cell_in_above_vcc, vcc_below_th}),
    .init_val (SYNC_INIT),
    .sync_out (pins_s)
  );

  assign {kick_drive_s, kick_s, mr_drive_s, mr_level_s,
          pfi_above_s, pfi_below_s, cell_test_low_s, cell_low_s,
          lowline_s, vcc_above_s, backup_cell_in_above_s, vcc_below_s} = pins_s;

  // ----------------------------------------------------------------
  // free-running timebase
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      tick_cnt <= {TICK_W{1'b0}};
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= {TICK_W{1'b0}};
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // reset generation
  // ----------------------------------------------------------------
  assign mr_active = mr_drive_s & ~mr_level_s;
  assign rst_cause = vcc_below_s | mr_active;

  sssl_hold_timer #(
    .CNT_W      (HOLD_W),
    .HOLD_TICKS (RST_TIMEOUT_MS)
  ) u_rst_hold (
    .mclk   (mclk),
    .rst    (rst),
    .tick   (tick),
    .cause  (rst_cause),
    .active (rst_hold)
  );

  always @(posedge mclk) begin
    if (rst) begin
      rst_n  <= 1'b0;
      rst_hi <= 1'b1;
    end else begin
      rst_n  <= ~rst_hold;
      rst_hi <= rst_hold;
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  assign kick_edge    = kick_s ^ kick_prev;
  assign wdog_enabled = kick_drive_s;

  always @(posedge mclk) begin
    if (rst) begin
      kick_prev      <= 1'b0;
      wdog_cnt       <= {WDOG_W{1'b0}};
      wdog_fired     <= 1'b0;
      wdog_expired_n <= 1'b1;
    end else begin
      kick_prev      <= kick_s;
      wdog_expired_n <= ~wdog_fired;
      if (kick_edge || rst_hold || !wdog_enabled) begin
        wdog_cnt <= {WDOG_W{1'b0}};
      end else if (tick && wdog_cnt != WDOG_LAST) begin
        wdog_cnt <= wdog_cnt + 1'b1;
      end
      if (kick_edge || rst_hold) begin
        wdog_fired <= 1'b0;
      end else if (wdog_enabled && tick && wdog_cnt == WDOG_LAST) begin
        wdog_fired <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // backup switchover
  // ----------------------------------------------------------------
  always @* begin
    next_backup_state = backup_state;
    case (backup_state)
      ST_MAIN: begin
        if (vcc_below_s && backup_cell_in_above_s) begin
          next_backup_state = ST_BACKUP;
        end
      end
      ST_BACKUP: begin
        if (vcc_above_s) begin
          next_backup_state = ST_MAIN;
        end
      end
      default: begin
        next_backup_state = ST_MAIN;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      backup_state <= ST_MAIN;
      on_backup    <= 1'b0;
    end else begin
      backup_state <= next_backup_state;
      on_backup    <= (next_backup_state == ST_BACKUP);
    end
  end

  // ----------------------------------------------------------------
  // periodic battery test
  // ----------------------------------------------------------------
  always @* begin
    next_test_state = test_state;
    case (test_state)
      ST_IDLE: begin
        if (tick && interval_done(intv_cnt, INTV_LAST)) begin
          next_test_state = ST_TEST;
        end
      end
      ST_TEST: begin
        if (tick && interval_done(pulse_cnt, PULSE_LAST)) begin
          next_test_state = ST_IDLE;
        end
      end
      default: begin
        next_test_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      test_state    <= ST_IDLE;
      intv_cnt      <= {INTV_W{1'b0}};
      pulse_cnt     <= {INTV_W{1'b0}};
      test_low_seen <= 1'b0;
      cell_failed   <= 1'b0;
    end else begin
      test_state <= next_test_state;
      if (tick) begin
        if (interval_done(intv_cnt, INTV_LAST)) begin
          intv_cnt <= {INTV_W{1'b0}};
        end else begin
          intv_cnt <= intv_cnt + 1'b1;
        end
      end
      if (test_state == ST_IDLE) begin
        pulse_cnt     <= {INTV_W{1'b0}};
        test_low_seen <= 1'b0;
      end else begin
        if (tick) begin
          pulse_cnt <= pulse_cnt + 1'b1;
        end
        if (cell_test_low_s) begin
          test_low_seen <= 1'b1;
        end
        if (next_test_state == ST_IDLE) begin
          cell_failed <= test_low_seen | cell_test_low_s;
        end
      end
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      cell_check_pulse_n  <= 1'b0;
      cell_check_pulse_oe <= 1'b0;
    end else begin
      cell_check_pulse_n  <= 1'b0;
      cell_check_pulse_oe <= (next_test_state == ST_TEST);
    end
  end

  // ----------------------------------------------------------------
  // battery-ok and low-line indications
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      cell_good      <= 1'b0;
      lowline_warn_n <= 1'b1;
    end else begin
      cell_good      <= ~(cell_low_s | cell_failed | (next_backup_state == ST_BACKUP));
      lowline_warn_n <= ~lowline_s;
    end
  end

  // ----------------------------------------------------------------
  // power-fail hysteresis
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      powerfail_n <= 1'b1;
    end else if (pfi_below_s) begin
      powerfail_n <= 1'b0;
    end else if (pfi_above_s) begin
      powerfail_n <= 1'b1;
    end
  end

endmodule

/* File: sim/sssl_monitor.sv */
// port-level assertions for the supply supervisor logic
module sssl_monitor #(
  parameter TICK_CYC       = 4,
  parameter RST_TIMEOUT_MS = 8,
  parameter WDOG_PERIOD_MS = 16,
  parameter TEST_PULSE_MS  = 5
) (
  input logic mclk,
  input logic rst,
  input logic vcc_below_th,
  input logic backup_cell_in_above_vcc,
  input logic vcc_above_backup_cell_in_scaled,
  input logic vcc_lowline,
  input logic cell_below_ok,
  input logic cell_below_test,
  input logic pfi_below,
  input logic pfi_above_hys,
  input logic manual_rst_n,
  input logic manual_rst_drive,
  input logic wdog_kick,
  input logic wdog_kick_drive,
  input logic rst_n,
  input logic rst_hi,
  input logic wdog_expired_n,
  input logic lowline_warn_n,
  input logic cell_check_pulse_n,
  input logic cell_check_pulse_oe,
  input logic cell_good,
  input logic on_backup,
  input logic powerfail_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD_LO = (WDOG_PERIOD_MS - 1) * TICK_CYC - 2;
  localparam int WD_HI = WDOG_PERIOD_MS * TICK_CYC + 6;
  localparam int PL    = TEST_PULSE_MS * TICK_CYC;
  int   idle;
  int   plen;
  logic kick_q;
  // cycles since the last watchdog restart cause, and pulse length
  always @(posedge mclk) begin
    kick_q <= wdog_kick;
    plen   <= cell_check_pulse_oe ? plen + 1 : 0;
    idle   <= (rst || !rst_n || !wdog_kick_drive || wdog_kick != kick_q) ? 0 : idle + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_pair: assert property (rst_hi != rst_n) else $error("reset outputs not complementary");
  a_manual_reset: assert property (manual_rst_drive && !manual_rst_n |-> ##[1:5] !rst_n)
    else $error("manual reset not asserted");
  a_supply_reset: assert property (vcc_below_th |-> ##[1:5] rst_hi) else $error("supply reset missing");
  a_backup_enter: assert property ((vcc_below_th && backup_cell_in_above_vcc)[*5] |-> on_backup)
    else $error("backup not entered");
  a_backup_only: assert property ((!vcc_below_th)[*5] |-> !$rose(on_backup))
    else $error("backup entered above threshold");
  a_backup_leave: assert property (vcc_above_backup_cell_in_scaled[*5] |-> !on_backup) else $error("backup not left");
  a_backup_flags: assert property (on_backup |-> !cell_good) else $error("cell good on backup");
  a_cell_low: assert property (cell_below_ok[*5] |-> !cell_good) else $error("cell good while low");
  a_lowline_warn: assert property (vcc_lowline[*5] |-> !lowline_warn_n) else $error("no low-line warn");
  a_pf_low: assert property (pfi_below[*5] |-> !powerfail_n) else $error("power fail missing");
  a_pf_high: assert property ((pfi_above_hys && !pfi_below)[*5] |-> powerfail_n)
    else $error("power fail stuck");
  a_test_len: assert property ($fell(cell_check_pulse_oe) |-> plen >= PL - 1 && plen <= PL + 1)
    else $error("test pulse length wrong");
  a_test_drive: assert property (cell_check_pulse_oe |-> !cell_check_pulse_n) else $error("test pin high");
  a_wdog_time: assert property ($fell(wdog_expired_n) |-> idle >= WD_LO && idle <= WD_HI)
    else $error("watchdog expiry time wrong");
  a_wdog_kick: assert property (wdog_kick_drive && $changed(wdog_kick) |-> ##[1:6] wdog_expired_n)
    else $error("watchdog not released by kick");
  a_wdog_reset: assert property ((!rst_n)[*3] |-> wdog_expired_n) else $error("watchdog held in reset");
  cover property ($fell(wdog_expired_n));
  cover property ($rose(on_backup));
  cover property ($fell(cell_check_pulse_oe) && !cell_good);
endmodule

/* File: sim/sssl_host_model.sv */
// host model: kicks the watchdog pin or leaves it undriven
module sssl_host_model (
  input  logic mclk,
  input  logic drive_en,
  input  logic kick_req,
  output logic wdog_kick,
  output logic wdog_kick_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic level = 1'b0;
  always @(posedge mclk) begin
    if (drive_en && kick_req) level <= ~level;
  end
  // released pin settles to the inverse of its last driven level
  assign wdog_kick       = drive_en ? level : ~level;
  assign wdog_kick_drive = drive_en;
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the supply supervisor logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T  = 4;
  localparam int RT = 8;
  localparam int WT = 16;
  localparam int PT = 5;
  localparam int IT = 50;
  logic mclk = 1'b0, rst = 1'b1, vcc_below_th = 1'b0, backup_cell_in_above_vcc = 1'b0, vcc_above_backup_cell_in_scaled = 1'b0;
  logic vcc_lowline = 1'b0, cell_below_ok = 1'b0, cell_below_test = 1'b0, pfi_below = 1'b0, pfi_above_hys = 1'b1;
  logic manual_rst_n = 1'b1, manual_rst_drive = 1'b0, kick_on = 1'b0, kick_req = 1'b0, pf = 1'b1;
  wire  wdog_kick, wdog_kick_drive, rst_n, rst_hi, wdog_expired_n, lowline_warn_n;
  wire  cell_check_pulse_n, cell_check_pulse_oe, cell_good, on_backup, powerfail_n;
  logic [31:0] seed = 32'h8aa5;
  int          n_errors = 0, checked = 0, cycles = 0, n, m;
  always #2 mclk = ~mclk;
  sssl_top #(.TICK_CYC(T), .RST_TIMEOUT_MS(RT), .WDOG_PERIOD_MS(WT), .TEST_PULSE_MS(PT), .TEST_INTV_MS(IT)) dut (
    .mclk, .rst, .vcc_below_th, .backup_cell_in_above_vcc, .vcc_above_backup_cell_in_scaled, .vcc_lowline, .cell_below_ok,
    .cell_below_test, .pfi_below, .pfi_above_hys, .manual_rst_n, .manual_rst_drive, .wdog_kick,
    .wdog_kick_drive, .rst_n, .rst_hi, .wdog_expired_n, .lowline_warn_n, .cell_check_pulse_n,
    .cell_check_pulse_oe, .cell_good, .on_backup, .powerfail_n);
  sssl_host_model host (.mclk, .drive_en(kick_on), .kick_req, .wdog_kick, .wdog_kick_drive);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic pf_exp(input logic below, input logic above, input logic prev);
    return below ? 1'b0 : (above ? 1'b1 : prev);
  endfunction
  function automatic logic sig(input int s);
    case (s)
      0: return rst_n;
      1: return wdog_expired_n;
      default: return cell_check_pulse_oe;
    endcase
  endfunction
  task automatic complete_run;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkn(input string what, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic wait_lvl(input int s, input logic v, output int k);
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (sig(s) !== v && k < 1000);
    if (sig(s) !== v) chk("wait level", v, sig(s));
  endtask
  task automatic kick;
    kick_req <= 1'b1;
    @(posedge mclk);
    kick_req <= 1'b0;
  endtask
  task automatic manual(input logic lvl);
    manual_rst_drive <= 1'b1;
    manual_rst_n <= lvl;
  endtask
  initial begin
    cyc(6);
    rst <= 1'b0;
    wait_lvl(0, 1'b1, n);
    chkn("reset hold", (RT - 1) * T, (RT + 1) * T + 6, n);
    manual(1'b0);
    cyc(8);
    chk("rst_n", 1'b0, rst_n);
    chk("rst_hi", 1'b1, rst_hi);
    manual_rst_n <= 1'b1;
    wait_lvl(0, 1'b1, n);
    chkn("manual hold", (RT - 1) * T, (RT + 1) * T + 6, n);
    manual_rst_drive <= 1'b0;
    manual_rst_n <= 1'b0;
    repeat (50) begin
      @(posedge mclk);
      chk("rst_n", 1'b1, rst_n);
    end
    manual_rst_n <= 1'b1;
    vcc_below_th <= 1'b1;
    backup_cell_in_above_vcc <= 1'b1;
    cyc(6);
    chk("rst_hi", 1'b1, rst_hi);
    chk("on_backup", 1'b1, on_backup);
    chk("cell_good", 1'b0, cell_good);
    vcc_below_th <= 1'b0;
    cyc(6);
    chk("on_backup", 1'b1, on_backup);
    vcc_above_backup_cell_in_scaled <= 1'b1;
    backup_cell_in_above_vcc <= 1'b0;
    cyc(6);
    chk("on_backup", 1'b0, on_backup);
    chk("cell_good", 1'b1, cell_good);
    vcc_above_backup_cell_in_scaled <= 1'b0;
    vcc_below_th <= 1'b1;
    cyc(6);
    chk("on_backup", 1'b0, on_backup);
    vcc_below_th <= 1'b0;
    wait_lvl(0, 1'b1, n);
    chkn("supply hold", (RT - 1) * T, (RT + 1) * T + 6, n);
    kick_on <= 1'b1;
    repeat (8) begin
      kick();
      cyc((WT - 2) * T);
    end
    chk("wdog_expired_n", 1'b1, wdog_expired_n);
    kick();
    wait_lvl(1, 1'b0, n);
    chkn("wdog timeout", (WT - 1) * T, WT * T + 8, n);
    kick();
    cyc(6);
    chk("wdog_expired_n", 1'b1, wdog_expired_n);
    wait_lvl(1, 1'b0, n);
    chk("wdog_expired_n", 1'b0, wdog_expired_n);
    manual(1'b0);
    cyc(8);
    chk("wdog_expired_n", 1'b1, wdog_expired_n);
    manual(1'b1);
    wait_lvl(0, 1'b1, n);
    kick_on <= 1'b0;
    cyc(WT * T * 3);
    chk("wdog_expired_n", 1'b1, wdog_expired_n);
    wait_lvl(2, 1'b0, n);
    wait_lvl(2, 1'b1, n);
    wait_lvl(2, 1'b0, n);
    chkn("test pulse", PT * T - 1, PT * T + 1, n);
    wait_lvl(2, 1'b1, m);
    chkn("test interval", IT * T - 1, IT * T + 1, n + m);
    cell_below_test <= 1'b1;
    wait_lvl(2, 1'b0, n);
    cyc(3);
    chk("cell_good", 1'b0, cell_good);
    cell_below_test <= 1'b0;
    wait_lvl(2, 1'b1, n);
    wait_lvl(2, 1'b0, n);
    cyc(3);
    chk("cell_good", 1'b1, cell_good);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      vcc_lowline <= seed[0];
      cell_below_ok <= seed[1];
      pfi_below <= seed[2] & seed[3];
      pfi_above_hys <= seed[4];
      cyc(6);
      pf = pf_exp(seed[2] & seed[3], seed[4], pf);
      chk("lowline_warn_n", ~seed[0], lowline_warn_n);
      chk("powerfail_n", pf, powerfail_n);
      chk("cell_good", ~seed[1], cell_good);
    end
    complete_run();
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
endmodule

bind sssl_top sssl_monitor #(.TICK_CYC(TICK_CYC), .RST_TIMEOUT_MS(RST_TIMEOUT_MS), .WDOG_PERIOD_MS(WDOG_PERIOD_MS),
  .TEST_PULSE_MS(TEST_PULSE_MS)) mon (.mclk, .rst, .vcc_below_th, .backup_cell_in_above_vcc, .vcc_above_backup_cell_in_scaled,
  .vcc_lowline, .cell_below_ok, .cell_below_test, .pfi_below, .pfi_above_hys, .manual_rst_n, .manual_rst_drive,
  .wdog_kick, .wdog_kick_drive, .rst_n, .rst_hi, .wdog_expired_n, .lowline_warn_n, .cell_check_pulse_n,
  .cell_check_pulse_oe, .cell_good, .on_backup, .powerfail_n);
